/* File: psp_sfr_space.sv */
// paged special function register space decode with page stack
// assumes the core gives one access per cycle and peripherals answer in the same cycle
`timescale 1ns/10ps
module psp_sfr_space
  import psp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // core access
  input wire logic acc_valid,
  input wire logic acc_direct,
  input wire logic acc_write,
  input wire logic acc_bit,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  // core interrupt events
  input wire logic irq_vector,
  input wire logic irq_from_vbus,
  input wire logic interrupt_return_instr,
  // peripheral side
  input wire logic [7:0] periph_rdata,
  input wire logic periph_hit,
  output logic periph_sel,
  output logic periph_write,
  output logic [7:0] periph_addr,
  output logic [7:0] periph_page,
  output logic [7:0] periph_wdata,
  // answers to the core
  output logic [7:0] acc_rdata,
  output logic acc_sfr,
  output logic acc_bit_ok,
  output logic acc_unmapped,
  output logic [7:0] page_select_reg
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic in_window(input logic [7:0] a);
    in_window = (a >= PSP_WIN_LO) && (a <= PSP_WIN_HI);
  endfunction : in_window

  function automatic logic bit_capable(input logic [7:0] a);
    bit_capable = (a[3:0] == PSP_BIT_NIB0) || (a[3:0] == PSP_BIT_NIB8);
  endfunction : bit_capable

  function automatic logic page_populated(input logic [7:0] p);
    page_populated = (p == PSP_PAGE_SYS) || (p == PSP_PAGE_VBUS) || (p == PSP_PAGE_CFG);
  endfunction : page_populated

  // ************************************************************
  // stack
  // ************************************************************
  psp_stack_if st ();

  psp_page_stack u_stack (
    .ref_clk(ref_clk),
    .reset(reset),
    .st(st)
  );

  logic sfr_hit;
  logic stack_loc;
  logic bit_ok;
  logic wr_ok;

  // the core never vectors and returns in one cycle; return yields to entry
  always_comb begin
    sfr_hit = acc_valid && acc_direct && in_window(acc_addr);
    bit_ok = !acc_bit || bit_capable(acc_addr);
    wr_ok = sfr_hit && acc_write && bit_ok;
    stack_loc = (acc_addr == PSP_ADDR_PAGE) || (acc_addr == PSP_ADDR_MIDDLE)
      || (acc_addr == PSP_ADDR_BOTTOM);
    st.push = irq_vector;
    st.pop = interrupt_return_instr && !irq_vector;
    st.push_page = irq_from_vbus ? PSP_PAGE_VBUS : PSP_PAGE_SYS;
    st.wr_page = wr_ok && (acc_addr == PSP_ADDR_PAGE);
    st.wr_middle = wr_ok && (acc_addr == PSP_ADDR_MIDDLE);
    st.wr_bottom = wr_ok && (acc_addr == PSP_ADDR_BOTTOM);
    st.wr_data = acc_wdata;
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  // one cycle of latency on every answer so all outputs come from flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      periph_sel <= 1'b0;
      periph_write <= 1'b0;
      periph_addr <= 8'h00;
      periph_page <= 8'h00;
      periph_wdata <= 8'h00;
    end else begin
      // peripheral select only for populated pages; periph_write is not gated by the page
      periph_sel <= sfr_hit && bit_ok && !stack_loc && page_populated(st.page);
      periph_write <= wr_ok && !stack_loc;
      periph_addr <= acc_addr;
      periph_page <= st.page;
      periph_wdata <= acc_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc_rdata <= 8'h00;
      acc_sfr <= 1'b0;
      acc_bit_ok <= 1'b0;
      acc_unmapped <= 1'b0;
    end else begin
      acc_sfr <= sfr_hit;
      acc_bit_ok <= sfr_hit && bit_ok;
      // undefined locations are flagged; they read zero only when periph_hit is low
      acc_unmapped <= sfr_hit && !stack_loc && (!page_populated(st.page) || !bit_ok);
      if (acc_addr == PSP_ADDR_PAGE) begin
        acc_rdata <= st.page;
      end else if (acc_addr == PSP_ADDR_MIDDLE) begin
        acc_rdata <= st.middle;
      end else if (acc_addr == PSP_ADDR_BOTTOM) begin
        acc_rdata <= st.bottom;
      end else begin
        acc_rdata <= periph_hit ? periph_rdata : 8'h00;
      end
    end
  end

  // mirror of the page entry, kept as its own flop for the top output
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      page_select_reg <= PSP_PAGE_RST;
    end else if (st.push) begin
      page_select_reg <= st.push_page;
    end else if (st.pop) begin
      page_select_reg <= st.middle;
    end else if (st.wr_page) begin
      page_select_reg <= st.wr_data;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  vector_page_a: assert property (@(posedge ref_clk) disable iff (reset)
    irq_vector |=> page_select_reg == ($past(irq_from_vbus) ? PSP_PAGE_VBUS : PSP_PAGE_SYS))
    else $error("wrong page after vectoring");
  nest_bottom_a: assert property (@(posedge ref_clk) disable iff (reset)
    irq_vector ##1 irq_vector |=> st.bottom == $past(page_select_reg, 2))
    else $error("nested push did not overwrite bottom");
  pop_page_a: assert property (@(posedge ref_clk) disable iff (reset)
    (interrupt_return_instr && !irq_vector) |=> page_select_reg == $past(st.middle))
    else $error("return did not restore page");
  window_hit_a: assert property (@(posedge ref_clk) disable iff (reset)
    (acc_valid && acc_direct && acc_addr[7]) |=> acc_sfr)
    else $error("window access not routed");
  low_half_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!acc_addr[7]) |=> !acc_sfr)
    else $error("lower half routed to register space");
  bit_reject_a: assert property (@(posedge ref_clk) disable iff (reset)
    (acc_valid && acc_direct && acc_bit && acc_addr[7] && acc_addr[2:0] != 3'h0)
      |=> !acc_bit_ok && !periph_sel)
    else $error("bit access allowed off column zero");
  page_mirror_a: assert property (@(posedge ref_clk) disable iff (reset)
    page_select_reg == st.page)
    else $error("page mirror diverged from stack");
  reset_zero_a: assert property (@(posedge ref_clk)
    $fell(reset) |-> page_select_reg == PSP_PAGE_RST && st.middle == PSP_PAGE_RST)
    else $error("page not zero after reset");

endmodule : psp_sfr_space

/* File: psp_pkg.sv */
// package for the paged register space block: constants and types
// assumes a single clock domain, synchronous active-high reset
package psp_pkg;

  // ************************************************************
  // address window
  // ************************************************************
  localparam logic [7:0] PSP_WIN_LO = 8'h80;
  localparam logic [7:0] PSP_WIN_HI = 8'hff;
  localparam logic [3:0] PSP_BIT_NIB0 = 4'h0;
  localparam logic [3:0] PSP_BIT_NIB8 = 4'h8;

  // ************************************************************
  // pages
  // ************************************************************
  localparam int PSP_PAGE_W = 8;
  localparam logic [7:0] PSP_PAGE_SYS = 8'h00;
  localparam logic [7:0] PSP_PAGE_VBUS = 8'h0c;
  localparam logic [7:0] PSP_PAGE_CFG = 8'h0f;
  localparam logic [7:0] PSP_PAGE_RST = 8'h00;

  // ************************************************************
  // stack register locations, reachable on every page
  // ************************************************************
  localparam logic [7:0] PSP_ADDR_PAGE = 8'ha7;
  localparam logic [7:0] PSP_ADDR_MIDDLE = 8'h85;
  localparam logic [7:0] PSP_ADDR_BOTTOM = 8'h86;

  typedef enum logic [1:0] {
    PSP_OP_NONE,
    PSP_OP_PUSH,
    PSP_OP_POP
  } psp_op_t;

endpackage : psp_pkg

/* File: psp_stack_if.sv */
// interface carrying the page stack controls between the decode and stack
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface psp_stack_if;
  import psp_pkg::*;
  logic push;
  logic pop;
  logic [7:0] push_page;
  logic wr_page;
  logic wr_middle;
  logic wr_bottom;
  logic [7:0] wr_data;
  logic [7:0] page;
  logic [7:0] middle;
  logic [7:0] bottom;
  logic bottom_valid;

  modport ctrl (output push, pop, push_page, wr_page, wr_middle, wr_bottom, wr_data,
    input page, middle, bottom, bottom_valid);
  modport stack (input push, pop, push_page, wr_page, wr_middle, wr_bottom, wr_data,
    output page, middle, bottom, bottom_valid);
endinterface : psp_stack_if

/* File: psp_page_stack.sv */
// three-entry page stack: page select, middle and bottom entries
// assumes push and pop are never both high in one cycle
`timescale 1ns/10ps
module psp_page_stack
  import psp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // stack controls
  psp_stack_if.stack st
);

  logic [7:0] page_select_reg;
  logic [7:0] page_stack_middle_reg;
  logic [7:0] page_stack_bottom_reg;
  logic bottom_valid_reg;

  // ************************************************************
  // stack shifting and software writes
  // ************************************************************
  // shifts take priority: a software write in the same cycle is dropped
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      page_select_reg <= PSP_PAGE_RST;
      page_stack_middle_reg <= PSP_PAGE_RST;
      page_stack_bottom_reg <= PSP_PAGE_RST;
      bottom_valid_reg <= 1'b0;
    end else if (st.push) begin
      page_select_reg <= st.push_page;
      page_stack_middle_reg <= page_select_reg;
      page_stack_bottom_reg <= page_stack_middle_reg;
      bottom_valid_reg <= 1'b1;
    end else if (st.pop) begin
      page_select_reg <= page_stack_middle_reg;
      // empty bottom gives page zero to the middle
      page_stack_middle_reg <= bottom_valid_reg ? page_stack_bottom_reg : PSP_PAGE_SYS;
      page_stack_bottom_reg <= PSP_PAGE_SYS;
      bottom_valid_reg <= 1'b0;
    end else begin
      // plain stores, no shifting
      if (st.wr_page) page_select_reg <= st.wr_data;
      if (st.wr_middle) page_stack_middle_reg <= st.wr_data;
      if (st.wr_bottom) begin
        page_stack_bottom_reg <= st.wr_data;
        bottom_valid_reg <= 1'b1;
      end
    end
  end

  assign st.page = page_select_reg;
  assign st.middle = page_stack_middle_reg;
  assign st.bottom = page_stack_bottom_reg;
  assign st.bottom_valid = bottom_valid_reg;

  // ************************************************************
  // checks
  // ************************************************************
  push_shift_a: assert property (@(posedge ref_clk) disable iff (reset)
    st.push |=> page_stack_middle_reg == $past(page_select_reg)
      && page_stack_bottom_reg == $past(page_stack_middle_reg))
    else $error("push did not shift the stack");
  pop_shift_a: assert property (@(posedge ref_clk) disable iff (reset)
    st.pop |=> page_select_reg == $past(page_stack_middle_reg))
    else $error("pop did not restore the page");
  pop_empty_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st.pop && !bottom_valid_reg) |=> page_stack_middle_reg == PSP_PAGE_SYS)
    else $error("empty pop did not give page zero");
  write_noshift_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st.wr_bottom && !st.push && !st.pop) |=> page_select_reg == $past(page_select_reg))
    else $error("stack write moved the page");

endmodule : psp_page_stack

/* File: psp_core_model.sv */
// core model: drives accesses and interrupt events into the paged register space
// assumes one caller process; requests change at the falling edge, one cycle unless nested
`timescale 1ns/10ps
module psp_core_model (
  // clock
  input wire logic ref_clk,
  // core access
  output logic acc_valid,
  output logic acc_direct,
  output logic acc_write,
  output logic acc_bit,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  // interrupt events
  output logic irq_vector,
  output logic irq_from_vbus,
  output logic interrupt_return_instr
);
  initial begin
    {acc_valid, acc_direct, acc_write, acc_bit, acc_addr, acc_wdata} = '0;
    {irq_vector, irq_from_vbus, interrupt_return_instr} = 3'h0;
  end

  // one access; a cycle passes between calls so the strobe never toggles twice in a step
  task automatic access(input logic dir, input logic wr, input logic bt,
      input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {acc_valid, acc_direct, acc_write, acc_bit, acc_addr, acc_wdata} = {1'b1, dir, wr, bt, a, d};
    @(negedge ref_clk);
    acc_valid = 1'b0;
  endtask : access

  // vector or return pulse, never both together
  task automatic event_op(input logic vec, input logic vbus, input logic ret);
    @(negedge ref_clk);
    {irq_vector, irq_from_vbus, interrupt_return_instr} = {vec, vbus, ret};
    @(negedge ref_clk);
    {irq_vector, irq_from_vbus, interrupt_return_instr} = 3'h0;
  endtask : event_op

  // vehicle bus vector, then a system vector on the very next edge: nested entry
  task automatic nest_op;
    @(negedge ref_clk);
    {irq_vector, irq_from_vbus} = 2'h3;
    @(negedge ref_clk);
    irq_from_vbus = 1'b0;
    @(negedge ref_clk);
    irq_vector = 1'b0;
  endtask : nest_op
endmodule : psp_core_model

/* File: psp_sfr_space_bench.sv */
// testbench for the paged register space: table of decodes, then stack sequences
// assumes the core model drives at the falling edge and outputs settle one cycle later
`timescale 1ns/10ps
module psp_sfr_space_bench;
  import psp_pkg::*;
  typedef struct packed {logic dir; logic bt; logic [7:0] addr; logic sfr; logic ok;} psp_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic acc_valid, acc_direct, acc_write, acc_bit, irq_vector, irq_from_vbus;
  logic interrupt_return_instr, periph_sel, periph_write, acc_sfr, acc_bit_ok, acc_unmapped;
  logic [7:0] acc_addr, acc_wdata, periph_addr, periph_page, periph_wdata, acc_rdata;
  logic [7:0] page_select_reg, periph_rdata;
  logic periph_hit;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  psp_row_t rows [8];
  logic [7:0] pg [5];

  // peripheral files answer at once; data tracks the address so a wrong mux shows
  assign periph_rdata = acc_addr ^ 8'h5a;
  // one location has no peripheral behind it, so a miss must read zero
  assign periph_hit = (acc_addr != 8'h91);

  always #4 ref_clk = ~ref_clk;

  psp_core_model core (.ref_clk(ref_clk), .acc_valid(acc_valid), .acc_direct(acc_direct),
    .acc_write(acc_write), .acc_bit(acc_bit), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .irq_vector(irq_vector), .irq_from_vbus(irq_from_vbus),
    .interrupt_return_instr(interrupt_return_instr));

  psp_sfr_space dut (.ref_clk(ref_clk), .reset(reset), .acc_valid(acc_valid),
    .acc_direct(acc_direct), .acc_write(acc_write), .acc_bit(acc_bit), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .irq_vector(irq_vector), .irq_from_vbus(irq_from_vbus),
    .interrupt_return_instr(interrupt_return_instr), .periph_rdata(periph_rdata),
    .periph_hit(periph_hit), .periph_sel(periph_sel), .periph_write(periph_write),
    .periph_addr(periph_addr), .periph_page(periph_page), .periph_wdata(periph_wdata),
    .acc_rdata(acc_rdata), .acc_sfr(acc_sfr), .acc_bit_ok(acc_bit_ok),
    .acc_unmapped(acc_unmapped), .page_select_reg(page_select_reg));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    core.access(1'b1, 1'b0, 1'b0, a, 8'h00);
    chk("acc_rdata", e, acc_rdata);
  endtask : rd

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // hang guard: the whole sequence needs about a hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      wrap_up();
    end
  end

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    rows = '{'{1'h1, 1'h0, 8'h90, 1'h1, 1'h1}, '{1'h1, 1'h1, 8'h88, 1'h1, 1'h1},
      '{1'h1, 1'h1, 8'h93, 1'h1, 1'h0}, '{1'h1, 1'h0, 8'h7f, 1'h0, 1'h0},
      '{1'h1, 1'h1, 8'h80, 1'h1, 1'h1}, '{1'h0, 1'h0, 8'h90, 1'h0, 1'h0},
      '{1'h1, 1'h1, 8'hf8, 1'h1, 1'h1}, '{1'h1, 1'h0, 8'hff, 1'h1, 1'h1}};
    pg = '{8'h00, 8'h0c, 8'h0f, 8'h05, 8'hff};
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    chk("page after reset", 8'h00, page_select_reg);
    rd(PSP_ADDR_MIDDLE, 8'h00);
    rd(PSP_ADDR_BOTTOM, 8'h00);
    foreach (rows[i]) begin
      core.access(rows[i].dir, 1'b0, rows[i].bt, rows[i].addr, 8'h00);
      chk("acc_sfr", {7'h0, rows[i].sfr}, {7'h0, acc_sfr});
      chk("periph_sel", {7'h0, rows[i].sfr & rows[i].ok}, {7'h0, periph_sel});
      if (rows[i].sfr) begin
        chk("acc_bit_ok", {7'h0, rows[i].ok}, {7'h0, acc_bit_ok});
        chk("acc_unmapped", {7'h0, ~rows[i].ok}, {7'h0, acc_unmapped});
      end
      if (rows[i].sfr & rows[i].ok) begin
        chk("acc_rdata", rows[i].addr ^ 8'h5a, acc_rdata);
        chk("periph_addr", rows[i].addr, periph_addr);
      end
    end
    rd(8'h91, 8'h00);
    foreach (pg[i]) begin
      core.access(1'b1, 1'b1, 1'b0, PSP_ADDR_PAGE, pg[i]);
      chk("page write", pg[i], page_select_reg);
      core.access(1'b1, 1'b0, 1'b0, 8'h90, 8'h00);
      chk("unmapped page", {7'h0, i > 2}, {7'h0, acc_unmapped});
      chk("periph_page", pg[i], periph_page);
    end
    core.access(1'b1, 1'b1, 1'b0, PSP_ADDR_PAGE, 8'h0f);
    core.access(1'b1, 1'b1, 1'b0, 8'h90, 8'ha5);
    chk("periph_write", 8'h01, {7'h0, periph_write});
    chk("periph_wdata", 8'ha5, periph_wdata);
    core.event_op(1'b1, 1'b0, 1'b0);
    chk("page on vector", 8'h00, page_select_reg);
    rd(PSP_ADDR_MIDDLE, 8'h0f);
    core.event_op(1'b1, 1'b1, 1'b0);
    chk("page on bus vector", 8'h0c, page_select_reg);
    rd(PSP_ADDR_MIDDLE, 8'h00);
    rd(PSP_ADDR_BOTTOM, 8'h0f);
    core.access(1'b1, 1'b1, 1'b0, PSP_ADDR_BOTTOM, 8'h33);
    chk("page after stack write", 8'h0c, page_select_reg);
    chk("periph_write on stack", 8'h00, {7'h0, periph_write});
    rd(PSP_ADDR_BOTTOM, 8'h33);
    core.event_op(1'b1, 1'b0, 1'b0);
    rd(PSP_ADDR_MIDDLE, 8'h0c);
    rd(PSP_ADDR_BOTTOM, 8'h00);
    core.event_op(1'b0, 1'b0, 1'b1);
    chk("page on return", 8'h0c, page_select_reg);
    rd(PSP_ADDR_MIDDLE, 8'h00);
    core.access(1'b1, 1'b1, 1'b0, PSP_ADDR_MIDDLE, 8'h0f);
    core.event_op(1'b0, 1'b0, 1'b1);
    chk("page after middle write", 8'h0f, page_select_reg);
    rd(PSP_ADDR_MIDDLE, 8'h00);
    // nested entry on back-to-back edges overwrites a software bottom value
    core.access(1'b1, 1'b1, 1'b0, PSP_ADDR_BOTTOM, 8'h33);
    core.nest_op();
    chk("page after nesting", 8'h00, page_select_reg);
    rd(PSP_ADDR_MIDDLE, 8'h0c);
    rd(PSP_ADDR_BOTTOM, 8'h0f);
    core.event_op(1'b0, 1'b0, 1'b1);
    rd(PSP_ADDR_MIDDLE, 8'h0f);
    core.event_op(1'b0, 1'b0, 1'b1);
    chk("page after two returns", 8'h0f, page_select_reg);
    core.access(1'b1, 1'b1, 1'b0, PSP_ADDR_MIDDLE, 8'h0c);
    @(negedge ref_clk);
    reset = 1'b1;
    @(negedge ref_clk);
    reset = 1'b0;
    chk("page after second reset", 8'h00, page_select_reg);
    rd(PSP_ADDR_MIDDLE, 8'h00);
    wrap_up();
  end
endmodule : psp_sfr_space_bench
